// [hw/dpr_defs.svh]
// Register map, field positions and timing constants of the loop ratio control block
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

// ======================================================================
// Register offsets (byte addresses on the bus)
`define DPR_ADR_W          8
`define DPR_OFF_IEN_CLR    8'h00
`define DPR_OFF_IEN_SET    8'h04
`define DPR_OFF_IRQ_FLAG   8'h08
`define DPR_OFF_STATUS     8'h0c
`define DPR_OFF_CTRL_B     8'h10

// ======================================================================
// Interrupt bit positions, shared by enable and flag registers
`define DPR_IRQ_LO         8
`define DPR_IRQ_HI         11
`define DPR_IRQ_N          4
`define DPR_IRQ_RATIO      3
`define DPR_IRQ_TIMEOUT    2
`define DPR_IRQ_LFALL      1
`define DPR_IRQ_LRISE      0

// ======================================================================
// Status bit positions
`define DPR_ST_LOCK        0
`define DPR_ST_TMR_BUSY    1
`define DPR_ST_REF_FAST    2

// ======================================================================
// Control register
`define DPR_CTRL_RESET     32'h0000_0000
`define DPR_CTRL_WMASK     32'h07ff_173f
`define DPR_REF_SLOW       2'h0
`define DPR_REF_FAST       2'h1
`define DPR_LT_NONE        3'h0
`define DPR_LT_MIN         3'h4
`define DPR_LT_BASE_MS     4'h8

// ======================================================================
// Timing
`define DPR_CLK_PERIOD_NS  8
`define DPR_MS_NS          1000000
`define DPR_SYNC_STAGES    3

`endif

// [hw/dpr_pkg.sv]
// Types shared by the loop ratio control block
package dpr_pkg;

   // Control register B layout, most significant field first
   typedef struct packed {
      logic [4:0]  rsvd_hi;
      logic [10:0] ref_divider;
      logic [2:0]  rsvd_b;
      logic        lock_signal_override;
      logic        rsvd_a;
      logic [2:0]  lock_timeout_select;
      logic [1:0]  rsvd_c;
      logic [1:0]  loop_reference_select;
      logic [3:0]  loop_tune;
   } dpr_ctrl_t;

   typedef enum logic [2:0] {
      DPR_TMR_IDLE = 3'b001,
      DPR_TMR_WAIT = 3'b010,
      DPR_TMR_DONE = 3'b100
   } dpr_tmr_state_t;

endpackage : dpr_pkg

// [hw/dpr_ref_div.sv]
// Divider for the fast crystal reference: output toggles every (div+1) rising crystal edges
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.svh"

module dpr_ref_div (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic        tick_i,
   input  wire logic [10:0] div_i,
   output logic             ref_o
);

   logic [10:0] cnt_q;
   logic        ref_q;

   // Held at rest while the slow crystal is the reference
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt_q <= 11'h000;
      end else if (tick_i) begin
         cnt_q <= (cnt_q >= div_i) ? 11'h000 : cnt_q + 11'h001;
      end
   end

   // Two toggles per period give f / (2 * (div + 1))
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         ref_q <= 1'b0;
      end else if (tick_i && cnt_q >= div_i) begin
         ref_q <= ~ref_q;
      end
   end

   assign ref_o = ref_q;

   a_div_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
      (run_i && tick_i && cnt_q == div_i) |=> (ref_o != $past(ref_o)))
      else $error("Divider did not toggle at terminal count");

endmodule : dpr_ref_div

`default_nettype wire

// [hw/dpr_lock_timer.sv]
// Lock timeout timer: counts milliseconds from loop enable until lock or timeout
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.svh"

module dpr_lock_timer #(
   parameter int unsigned MS_CYCLES = `DPR_MS_NS / `DPR_CLK_PERIOD_NS
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic       locked_i,
   input  wire logic [2:0] lock_timeout_select_i,
   output logic            timeout_o,
   output logic            busy_o
);

   localparam int unsigned CW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;

   dpr_pkg::dpr_tmr_state_t state_q;
   logic [CW-1:0]           pre_q;
   logic [3:0]              ms_q;
   logic                    timeout_q;
   logic [2:0]              lt_off;
   logic [3:0]              limit;
   logic                    ms_tick;
   logic                    armed;

   // Codes below the first timeout code (0 and the reserved ones) never time out
   assign armed   = (lock_timeout_select_i >= `DPR_LT_MIN);
   assign lt_off  = lock_timeout_select_i - `DPR_LT_MIN;
   assign limit   = `DPR_LT_BASE_MS + {1'b0, lt_off};
   assign ms_tick = (pre_q == CW'(MS_CYCLES - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= dpr_pkg::DPR_TMR_IDLE;
      end else begin
         case (state_q)
            dpr_pkg::DPR_TMR_IDLE: begin
               if (enable_i && armed && !locked_i) state_q <= dpr_pkg::DPR_TMR_WAIT;
            end
            dpr_pkg::DPR_TMR_WAIT: begin
               if (!enable_i || !armed) state_q <= dpr_pkg::DPR_TMR_IDLE;
               else if (locked_i) state_q <= dpr_pkg::DPR_TMR_DONE;
               else if (ms_tick && ms_q + 4'h1 >= limit) state_q <= dpr_pkg::DPR_TMR_DONE;
            end
            dpr_pkg::DPR_TMR_DONE: begin
               if (!enable_i) state_q <= dpr_pkg::DPR_TMR_IDLE;
            end
            default: state_q <= dpr_pkg::DPR_TMR_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || state_q != dpr_pkg::DPR_TMR_WAIT) begin
         pre_q <= '0;
         ms_q  <= 4'h0;
      end else begin
         pre_q <= ms_tick ? '0 : pre_q + CW'(1);
         if (ms_tick) ms_q <= ms_q + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= (state_q == dpr_pkg::DPR_TMR_WAIT) && enable_i && armed && !locked_i
                      && ms_tick && (ms_q + 4'h1 >= limit);
      end
   end

   assign timeout_o = timeout_q;
   assign busy_o    = (state_q == dpr_pkg::DPR_TMR_WAIT);

   a_tmr_no_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
      (lock_timeout_select_i < `DPR_LT_MIN) |=> !busy_o)
      else $error("Timer ran with a non-timeout lock time code");

endmodule : dpr_lock_timer

`default_nettype wire

// [hw/dpr_ctrl_top.sv]
// Loop ratio control block: bus registers, interrupt enables, lock and reference control
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.svh"

module dpr_ctrl_top #(
   parameter int unsigned MS_CYCLES = `DPR_MS_NS / `DPR_CLK_PERIOD_NS
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [`DPR_ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic      [31:0]            wb_dat_o,
   output logic                        wb_ack_o,
   input  wire logic                   loop_enable_i,
   input  wire logic                   ratio_done_i,
   input  wire logic                   pll_lock_raw_i,
   input  wire logic                   fast_crystal_source_i,
   input  wire logic                   slow_crystal_source_i,
   output logic                        loop_ref_o,
   output logic                        loop_lock_o,
   output logic      [3:0]             loop_tune_o,
   output logic                        irq_o
);

   // ======================================================================
   // Input synchronisers
   localparam int unsigned NSYNC = 3;
   localparam int unsigned SI_LOCK = 0;
   localparam int unsigned SI_FAST = 1;
   localparam int unsigned SI_SLOW = 2;

   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] stable_q;

   assign async_in = {slow_crystal_source_i, fast_crystal_source_i, pll_lock_raw_i};

   // A change is accepted only once the second and third stages agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         logic [`DPR_SYNC_STAGES-1:0] sh_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               sh_q        <= '0;
               stable_q[gi] <= 1'b0;
            end else begin
               sh_q <= {sh_q[`DPR_SYNC_STAGES-2:0], async_in[gi]};
               if (sh_q[1] == sh_q[2]) stable_q[gi] <= sh_q[2];
            end
         end
      end
   endgenerate

   // ======================================================================
   // Bus slave: one wait state, ack for one cycle, write lands on the ack edge
   logic        ack_q;
   logic [31:0] rdat_q;
   logic        req;
   logic        wr_acc;
   logic [31:0] be_mask;
   logic [31:0] wdat;
   logic        wr_ien_clr;
   logic        wr_ien_set;
   logic        wr_flag;
   logic        wr_ctrl;

   assign req     = wb_cyc_i && wb_stb_i;
   assign wr_acc  = req && wb_we_i && ack_q;
   assign be_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat    = wb_dat_i & be_mask;

   assign wr_ien_clr = wr_acc && (wb_adr_i == `DPR_OFF_IEN_CLR);
   assign wr_ien_set = wr_acc && (wb_adr_i == `DPR_OFF_IEN_SET);
   assign wr_flag    = wr_acc && (wb_adr_i == `DPR_OFF_IRQ_FLAG);
   assign wr_ctrl    = wr_acc && (wb_adr_i == `DPR_OFF_CTRL_B);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req && !ack_q;
      end
   end

   // ======================================================================
   // Control register B
   dpr_pkg::dpr_ctrl_t ctrl_q;

   // Reserved bits cannot be set, so they always read back as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `DPR_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= (ctrl_q & ~(be_mask & `DPR_CTRL_WMASK)) | (wdat & `DPR_CTRL_WMASK);
      end
   end

   assign loop_tune_o = ctrl_q.loop_tune;

   // ======================================================================
   // Interrupt enables: separate set and clear views of one register
   logic [`DPR_IRQ_N-1:0] ien_q;
   logic [`DPR_IRQ_N-1:0] ien_wset;
   logic [`DPR_IRQ_N-1:0] ien_wclr;
   logic                  loop_ratio_done_irq_en;
   logic                  lock_timeout_irq_en;
   logic                  lock_lost_irq_en;

   assign ien_wset = wr_ien_set ? wdat[`DPR_IRQ_HI:`DPR_IRQ_LO] : '0;
   assign ien_wclr = wr_ien_clr ? wdat[`DPR_IRQ_HI:`DPR_IRQ_LO] : '0;

   // A zero written to either view leaves the enable as it was
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ien_q <= '0;
      end else begin
         ien_q <= (ien_q | ien_wset) & ~ien_wclr;
      end
   end

   assign loop_ratio_done_irq_en = ien_q[`DPR_IRQ_RATIO];
   assign lock_timeout_irq_en    = ien_q[`DPR_IRQ_TIMEOUT];
   assign lock_lost_irq_en       = ien_q[`DPR_IRQ_LFALL];

   // ======================================================================
   // Lock indication
   logic lock_eff;
   logic lock_q;

   assign lock_eff = ctrl_q.lock_signal_override || stable_q[SI_LOCK];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= lock_eff;
      end
   end

   assign loop_lock_o = lock_q;

   // ======================================================================
   // Lock timeout
   logic tmr_timeout;
   logic tmr_busy;

   dpr_lock_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timer (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .enable_i  (loop_enable_i),
      .locked_i  (lock_eff),
      .lock_timeout_select_i   (ctrl_q.lock_timeout_select),
      .timeout_o (tmr_timeout),
      .busy_o    (tmr_busy)
   );

   // ======================================================================
   // Reference selection
   logic fast_sel;
   logic fast_prev_q;
   logic fast_tick;
   logic div_ref;
   logic ref_q;

   assign fast_sel  = (ctrl_q.loop_reference_select == `DPR_REF_FAST);
   assign fast_tick = stable_q[SI_FAST] && !fast_prev_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_prev_q <= 1'b0;
      end else begin
         fast_prev_q <= stable_q[SI_FAST];
      end
   end

   // The divider is parked while the slow crystal drives the loop
   dpr_ref_div u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (fast_sel),
      .tick_i (fast_tick),
      .div_i  (ctrl_q.ref_divider),
      .ref_o  (div_ref)
   );

   // Codes 2 and 3 fall back to the slow crystal rather than stopping the loop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ref_q <= 1'b0;
      end else begin
         ref_q <= fast_sel ? div_ref : stable_q[SI_SLOW];
      end
   end

   assign loop_ref_o = ref_q;

   // ======================================================================
   // Interrupt flags: hardware set wins over a same-cycle software clear
   logic [`DPR_IRQ_N-1:0] flag_q;
   logic [`DPR_IRQ_N-1:0] flag_set;
   logic [`DPR_IRQ_N-1:0] flag_clr;

   always_comb begin
      flag_set                   = '0;
      flag_set[`DPR_IRQ_RATIO]   = ratio_done_i;
      flag_set[`DPR_IRQ_TIMEOUT] = tmr_timeout;
      flag_set[`DPR_IRQ_LFALL]   = lock_q && !lock_eff;
      flag_set[`DPR_IRQ_LRISE]   = !lock_q && lock_eff;
   end

   assign flag_clr = wr_flag ? wdat[`DPR_IRQ_HI:`DPR_IRQ_LO] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= '0;
      end else begin
         flag_q <= (flag_q & ~flag_clr) | flag_set;
      end
   end

   assign irq_o = |(flag_q & ien_q);

   // ======================================================================
   // Read data, captured in the request cycle and presented with ack
   logic [31:0] rdat_d;
   logic [31:0] status;

   always_comb begin
      status                    = '0;
      status[`DPR_ST_LOCK]      = lock_q;
      status[`DPR_ST_TMR_BUSY]  = tmr_busy;
      status[`DPR_ST_REF_FAST]  = fast_sel;
   end

   always_comb begin
      rdat_d = '0;
      case (wb_adr_i)
         `DPR_OFF_IEN_CLR:  rdat_d[`DPR_IRQ_HI:`DPR_IRQ_LO] = ien_q;
         `DPR_OFF_IEN_SET:  rdat_d[`DPR_IRQ_HI:`DPR_IRQ_LO] = ien_q;
         `DPR_OFF_IRQ_FLAG: rdat_d[`DPR_IRQ_HI:`DPR_IRQ_LO] = flag_q;
         `DPR_OFF_STATUS:   rdat_d = status;
         `DPR_OFF_CTRL_B:   rdat_d = ctrl_q;
         default:           rdat_d = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_q <= '0;
      end else if (req && !ack_q) begin
         rdat_q <= rdat_d;
      end
   end

   assign wb_dat_o = rdat_q;
   assign wb_ack_o = ack_q;

   // ======================================================================
   // Checks
   a_ien_ratio_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ien_set && wdat[`DPR_IRQ_LO + `DPR_IRQ_RATIO]) |=> loop_ratio_done_irq_en)
      else $error("Ratio-done enable not set by write of one");

   a_ien_timeout_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ien_set && wdat[`DPR_IRQ_LO + `DPR_IRQ_TIMEOUT]) |=> lock_timeout_irq_en)
      else $error("Timeout enable not set by write of one");

   a_ien_lfall_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ien_set && wdat[`DPR_IRQ_LO + `DPR_IRQ_LFALL]) |=> lock_lost_irq_en)
      else $error("Lock-lost enable not set by write of one");

   a_ien_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_ien_set && !wdat[`DPR_IRQ_LO + `DPR_IRQ_TIMEOUT]) |=>
      (lock_timeout_irq_en == $past(lock_timeout_irq_en)))
      else $error("Zero written to enable-set changed an enable");

   a_irq_on_event: assert property (@(posedge clk_i) disable iff (rst_i)
      (tmr_timeout && lock_timeout_irq_en && !wr_ien_clr) |=> irq_o)
      else $error("Enabled timeout event raised no interrupt");

   a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
      (ien_q == '0) |-> !irq_o)
      else $error("Interrupt raised with all enables clear");

   a_bypass_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.lock_signal_override |=> loop_lock_o)
      else $error("Lock not held asserted under bypass");

   a_lock_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      !ctrl_q.lock_signal_override |=> (loop_lock_o == $past(stable_q[SI_LOCK])))
      else $error("Lock output does not follow the real lock");

   a_ref_slow_path: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_q.loop_reference_select == `DPR_REF_SLOW) |=> (loop_ref_o == $past(stable_q[SI_SLOW])))
      else $error("Slow crystal not routed to the reference");

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held for more than one cycle");

endmodule : dpr_ctrl_top

`default_nettype wire

// [verif/test_dpr_ctrl_top.sv]
// Self-checking testbench for the loop ratio control block
`timescale 1ns/1ps
`default_nettype none
`include "dpr_defs.svh"

module test_dpr_ctrl_top;
   localparam int unsigned MS = 10;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, ld_ref, ld_lock, irq_o;
   logic [3:0]  tune;
   logic        en = 1'b0, rdone = 1'b0, lraw = 1'b0, fast = 1'b0, slow = 1'b0;
   logic [7:0]  ph = 8'h00;
   logic [31:0] exp_q[$];
   int          err_total = 0, n_checks = 0, cyc_cnt = 0, p, acc;
   int          tbl[4][3] = '{'{1, 2, 24}, '{1, 0, 8}, '{0, 2, 16}, '{1, 5, 48}};
   int          lts[6] = '{0, 2, 4, 5, 6, 7};

   dpr_ctrl_top #(.MS_CYCLES(MS)) dpr_ctrl_top_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .loop_enable_i(en), .ratio_done_i(rdone), .pll_lock_raw_i(lraw),
      .fast_crystal_source_i(fast), .slow_crystal_source_i(slow),
      .loop_ref_o(ld_ref), .loop_lock_o(ld_lock), .loop_tune_o(tune), .irq_o(irq_o));

   always #4 clk_i = ~clk_i;

   // Crystal stand-ins: fast period 4 cycles, slow period 16 cycles
   always @(posedge clk_i) begin
      ph   <= ph + 8'h01;
      fast <= ph[1];
      slow <= ph[3];
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : check

   // Classic single cycle; reads note their expectation for the monitor
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w) exp_q.push_back(d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= w ? d : 32'h0;
      // Only the bench timeout ends a wait for ack
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) begin
            err_total++;
         end else begin
            check(wb_dat_o, exp_q.pop_front());
         end
      end
   end

   // A hang ends the run as a mismatch
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt > 20000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic wait_ref(input logic v, inout int n);
      while (ld_ref !== v && n < 500) begin
         @(posedge clk_i);
         n++;
      end
   endtask : wait_ref

   task automatic ref_period(output int per);
      int n, m;
      n = 0;
      wait_ref(1'b0, n);
      wait_ref(1'b1, n);
      m = n;
      wait_ref(1'b0, n);
      wait_ref(1'b1, n);
      per = n - m;
   endtask : ref_period

   task automatic pulse_done();
      rdone <= 1'b1;
      @(posedge clk_i);
      rdone <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : pulse_done

   initial begin
      logic [31:0] v;
      void'($urandom(66));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // ==========================================
      // Reset values and control register storage
      wb(1'b0, `DPR_OFF_CTRL_B, 32'h0);
      wb(1'b0, `DPR_OFF_IEN_SET, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom();
         wb(1'b1, `DPR_OFF_CTRL_B, v);
         wb(1'b0, `DPR_OFF_CTRL_B, v & `DPR_CTRL_WMASK);
         check({28'h0, tune}, {28'h0, v[3:0]});
      end
      wb(1'b1, `DPR_OFF_CTRL_B, 32'h0);
      repeat (8) @(posedge clk_i);
      wb(1'b1, `DPR_OFF_IRQ_FLAG, 32'h0000_0f00);
      // ==========================================
      // Enable set view: ones set, zeros leave alone
      acc = 0;
      for (int b = 9; b < 12; b++) begin
         acc = acc | (1 << b);
         wb(1'b1, `DPR_OFF_IEN_SET, ($urandom() & 32'hffff_f0ff) | (32'h1 << b));
         wb(1'b0, `DPR_OFF_IEN_SET, 32'(acc));
         wb(1'b1, `DPR_OFF_IEN_SET, 32'h0);
         wb(1'b0, `DPR_OFF_IEN_SET, 32'(acc));
      end
      wb(1'b0, 8'h20, 32'h0);
      wb(1'b1, 8'h20, 32'hffff_ffff);
      wb(1'b0, `DPR_OFF_CTRL_B, 32'h0);
      // ==========================================
      // Interrupt follows enable and flag
      pulse_done();
      check({31'h0, irq_o}, 32'h1);
      wb(1'b1, `DPR_OFF_IRQ_FLAG, 32'h0000_0800);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, `DPR_OFF_IEN_CLR, 32'h0000_0800);
      pulse_done();
      check({31'h0, irq_o}, 32'h0);
      wb(1'b0, `DPR_OFF_IRQ_FLAG, 32'h0000_0800);
      wb(1'b1, `DPR_OFF_IRQ_FLAG, 32'h0000_0800);
      // ==========================================
      // Lock timeout for settings 0, 2 and 4 to 7, reserved code 2 included
      foreach (lts[k]) begin
         p = (lts[k] >= 4) ? (8 + lts[k] - 4) * MS : 150;
         wb(1'b1, `DPR_OFF_CTRL_B, 32'(lts[k]) << 8);
         en <= 1'b1;
         repeat (p - 9) @(posedge clk_i);
         wb(1'b0, `DPR_OFF_IRQ_FLAG, 32'h0);
         repeat (10) @(posedge clk_i);
         wb(1'b0, `DPR_OFF_IRQ_FLAG, (lts[k] >= 4) ? 32'h0000_0400 : 32'h0);
         check({31'h0, irq_o}, (lts[k] >= 4) ? 32'h1 : 32'h0);
         en <= 1'b0;
         wb(1'b1, `DPR_OFF_IRQ_FLAG, 32'h0000_0400);
      end
      // ==========================================
      // Reference selection and divider
      foreach (tbl[k]) begin
         wb(1'b1, `DPR_OFF_CTRL_B, (32'(tbl[k][1]) << 16) | (32'(tbl[k][0]) << 4));
         repeat (60) @(posedge clk_i);
         ref_period(p);
         check(32'(p), 32'(tbl[k][2]));
      end
      // ==========================================
      // Lock override and real lock, with lock loss interrupt
      wb(1'b1, `DPR_OFF_CTRL_B, 32'h0000_1000);
      repeat (8) @(posedge clk_i);
      check({31'h0, ld_lock}, 32'h1);
      wb(1'b1, `DPR_OFF_CTRL_B, 32'h0);
      repeat (8) @(posedge clk_i);
      check({31'h0, ld_lock}, 32'h0);
      lraw <= 1'b1;
      repeat (8) @(posedge clk_i);
      check({31'h0, ld_lock}, 32'h1);
      // Status shows the real lock; timer idle and slow reference selected
      wb(1'b0, `DPR_OFF_STATUS, 32'h0000_0001);
      wb(1'b1, `DPR_OFF_IRQ_FLAG, 32'h0000_0f00);
      lraw <= 1'b0;
      repeat (8) @(posedge clk_i);
      check({31'h0, irq_o}, 32'h1);
      wb(1'b0, `DPR_OFF_IRQ_FLAG, 32'h0000_0200);
      repeat (4) @(posedge clk_i);
      check(32'(exp_q.size()), 32'h0);
      end_sim();
   end
endmodule : test_dpr_ctrl_top

`default_nettype wire
